// ===== shared/adcseq_pkg.sv
// Constants and types for the conversion sequencer
package adcseq_pkg;
  // Register indices on the plain register port
  localparam logic [2:0] ADDR_RESULT_HIGH = 3'h0;
  localparam logic [2:0] ADDR_RESULT_LOW = 3'h1;
  localparam logic [2:0] ADDR_CONTROL_ZERO = 3'h2;
  localparam logic [2:0] ADDR_CONTROL_ONE = 3'h3;
  localparam logic [2:0] ADDR_CONTROL_TWO = 3'h4;
  localparam logic [2:0] ADDR_STATUS = 3'h5;
  localparam logic [2:0] ADDR_COMPARE2 = 3'h6;
  // Control zero fields
  localparam int CZ_CAL = 7;
  localparam int CZ_GO = 1;
  localparam int CZ_ON = 0;
  localparam int CZ_CHS_LSB = 2;
  // Control two fields
  localparam int CT_JUSTIFY = 7;
  localparam int CT_ACQ_LSB = 3;
  localparam int CT_CLK_LSB = 0;
  // Masks of implemented bits
  localparam logic [7:0] CZ_MASK = 8'hBF;
  localparam logic [7:0] CO_MASK = 8'h3F;
  localparam logic [7:0] CT_MASK = 8'hBF;
  localparam logic [7:0] CP_MASK = 8'h3F;
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [3:0] COMPARE2_ADC_TRIGGER = 4'hB;
  // Sequence figures in bit periods
  localparam logic [4:0] CONV_PERIODS = 5'h0B;
  localparam logic [4:0] WAIT_PERIODS = 5'h02;
  localparam int RESULT_BITS = 10;
  // One instruction cycle is four oscillator periods
  localparam logic [7:0] INSTR_CYCLE_CLKS = 8'h04;
  typedef enum logic [2:0] {
    ADCSEQ_IDLE, ADCSEQ_DELAY, ADCSEQ_ACQ, ADCSEQ_CONV, ADCSEQ_WAIT
  } adcseq_state_t;
endpackage

// ===== rtl/adcseq_top.sv
// Successive-approximation converter sequencer with register port
`timescale 1ns/1ps
// Behaviour
// - Conversion takes exactly eleven bit periods
// - Clock select field sets bit period
// - Analog pins read low on ports
// - Channel and direction never gate conversion
// - Zero acquisition delays start one instruction
// - Acquisition field sets sampling before conversion
// - Clearing go aborts, result kept
// - Two period wait after end
// - Compare two trigger sets go
// - Trigger resets associated timer counter
// - Trigger starts no conversion while converter off
// - Calibration request runs dummy offset conversion
// - Completion loads result unless calibrating, clears go, flags
// - Acquisition field encodes bit period counts
// - Justify bit places result
// - Reset turns converter off, aborts
module adcseq_top (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_rc_tick,
  input wire logic i_special_event,
  input wire logic i_cmp_bit,
  input wire logic [15:0] i_pin_level,
  output logic [7:0] o_rdata,
  output logic o_sample,
  output logic o_cal_mode,
  output logic [9:0] o_dac_code,
  output logic [3:0] o_channel,
  output logic o_timer_reset,
  output logic o_conversion_done_flag,
  output logic [15:0] o_port_level
);
  logic [7:0] result_high;
  logic [7:0] result_low;
  logic [7:0] control_zero;
  logic [7:0] control_one;
  logic [7:0] control_two;
  logic [7:0] compare2_control;
  logic conversion_done_flag;
  logic [9:0] offset;
  logic cal_run;
  adcseq_pkg::adcseq_state_t state;
  logic [6:0] div_cnt;
  logic tad_tick;
  logic [4:0] period_cnt;
  logic [7:0] delay_cnt;
  logic [9:0] sar;
  logic [9:0] trial;
  logic [3:0] bit_idx;
  logic [6:0] div_len;
  logic [4:0] acq_len;
  logic [9:0] corrected;
  logic [9:0] final_code;
  logic go_write_set;
  logic go_write_clear;
  logic trigger_go;
  logic conv_end;
  logic busy;

  wire logic [2:0] clk_sel = control_two[adcseq_pkg::CT_CLK_LSB +: 3];
  wire logic [2:0] acq_sel = control_two[adcseq_pkg::CT_ACQ_LSB +: 3];
  wire logic conv_on = control_zero[adcseq_pkg::CZ_ON];
  wire logic go_flag = control_zero[adcseq_pkg::CZ_GO];
  wire logic use_rc = (clk_sel[1:0] == 2'h3);

  always_comb begin
    unique case (clk_sel)
      3'h0: div_len = 7'h02;
      3'h4: div_len = 7'h04;
      3'h1: div_len = 7'h08;
      3'h5: div_len = 7'h10;
      3'h2: div_len = 7'h20;
      3'h6: div_len = 7'h40;
      default: div_len = 7'h01;
    endcase
  end

  always_comb begin
    unique case (acq_sel)
      3'h0: acq_len = 5'h00;
      3'h1: acq_len = 5'h02;
      3'h2: acq_len = 5'h04;
      3'h3: acq_len = 5'h06;
      3'h4: acq_len = 5'h08;
      3'h5: acq_len = 5'h0C;
      3'h6: acq_len = 5'h10;
      default: acq_len = 5'h14;
    endcase
  end

  // Period divider restarts with each sequence so phases align
  always_ff @(posedge i_clk) begin
    // Abort restarts the divider; free RC phase cannot be restarted
    if (!i_rst_n || state == adcseq_pkg::ADCSEQ_IDLE || state == adcseq_pkg::ADCSEQ_DELAY
      || (busy && go_write_clear)) begin
      div_cnt <= 7'h00;
      tad_tick <= 1'b0;
    end else if (use_rc) begin
      div_cnt <= 7'h00;
      tad_tick <= i_rc_tick;
    end else if (div_cnt == div_len - 7'h01) begin
      div_cnt <= 7'h00;
      tad_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 7'h01;
      tad_tick <= 1'b0;
    end
  end

  assign go_write_set = i_wr && i_addr == adcseq_pkg::ADDR_CONTROL_ZERO
    && i_wdata[adcseq_pkg::CZ_GO] && i_wdata[adcseq_pkg::CZ_ON] && conv_on;
  assign go_write_clear = i_wr && i_addr == adcseq_pkg::ADDR_CONTROL_ZERO
    && !i_wdata[adcseq_pkg::CZ_GO];
  assign trigger_go = i_special_event && conv_on
    && compare2_control[3:0] == adcseq_pkg::COMPARE2_ADC_TRIGGER;
  assign busy = state == adcseq_pkg::ADCSEQ_DELAY || state == adcseq_pkg::ADCSEQ_ACQ
    || state == adcseq_pkg::ADCSEQ_CONV;
  assign conv_end = state == adcseq_pkg::ADCSEQ_CONV && tad_tick
    && period_cnt == adcseq_pkg::CONV_PERIODS - 5'h01;

  // Channel and direction bits never consulted here
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= adcseq_pkg::ADCSEQ_IDLE;
      period_cnt <= 5'h00;
      delay_cnt <= 8'h00;
    end else if (!conv_on) begin
      state <= adcseq_pkg::ADCSEQ_IDLE;
      period_cnt <= 5'h00;
    end else begin
      unique case (state)
        adcseq_pkg::ADCSEQ_IDLE: begin
          period_cnt <= 5'h00;
          delay_cnt <= 8'h00;
          if (go_write_set || trigger_go) begin
            // One instruction delay for sleep entry
            if (acq_sel == 3'h0)
              state <= adcseq_pkg::ADCSEQ_DELAY;
            else
              state <= adcseq_pkg::ADCSEQ_ACQ;
          end
        end
        adcseq_pkg::ADCSEQ_DELAY: begin
          delay_cnt <= delay_cnt + 8'h01;
          if (go_write_clear)
            state <= adcseq_pkg::ADCSEQ_WAIT;
          else if (delay_cnt == adcseq_pkg::INSTR_CYCLE_CLKS - 8'h01)
            state <= adcseq_pkg::ADCSEQ_CONV;
        end
        adcseq_pkg::ADCSEQ_ACQ: begin
          if (go_write_clear) begin
            state <= adcseq_pkg::ADCSEQ_WAIT;
            period_cnt <= 5'h00;
          end else if (tad_tick) begin
            if (period_cnt == acq_len - 5'h01) begin
              state <= adcseq_pkg::ADCSEQ_CONV;
              period_cnt <= 5'h00;
            end else begin
              period_cnt <= period_cnt + 5'h01;
            end
          end
        end
        adcseq_pkg::ADCSEQ_CONV: begin
          if (go_write_clear || conv_end) begin
            state <= adcseq_pkg::ADCSEQ_WAIT;
            period_cnt <= 5'h00;
          end else if (tad_tick) begin
            period_cnt <= period_cnt + 5'h01;
          end
        end
        adcseq_pkg::ADCSEQ_WAIT: begin
          // Two period wait then sample again
          if (tad_tick) begin
            if (period_cnt == adcseq_pkg::WAIT_PERIODS - 5'h01) begin
              state <= adcseq_pkg::ADCSEQ_IDLE;
              period_cnt <= 5'h00;
            end else begin
              period_cnt <= period_cnt + 5'h01;
            end
          end
        end
      endcase
    end
  end

  // One decision per period, MSB first
  assign trial = sar | (10'h200 >> bit_idx);
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || state != adcseq_pkg::ADCSEQ_CONV) begin
      sar <= 10'h000;
      bit_idx <= 4'h0;
    end else if (tad_tick && bit_idx < 4'(adcseq_pkg::RESULT_BITS)) begin
      if (i_cmp_bit)
        sar <= trial;
      bit_idx <= bit_idx + 4'h1;
    end
  end

  // Trial code shown to the array while resolving
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_dac_code <= 10'h000;
    end else if (state == adcseq_pkg::ADCSEQ_CONV && bit_idx < 4'(adcseq_pkg::RESULT_BITS)) begin
      o_dac_code <= trial;
    end else begin
      o_dac_code <= sar;
    end
  end

  // Final code includes the decision of the last period
  assign final_code = (bit_idx < 4'(adcseq_pkg::RESULT_BITS) && i_cmp_bit) ? trial : sar;
  // Offset clamps at zero rather than wrapping
  assign corrected = (final_code > offset) ? final_code - offset : 10'h000;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cal_run <= 1'b0;
      offset <= 10'h000;
    end else begin
      if (state == adcseq_pkg::ADCSEQ_IDLE && (go_write_set || trigger_go))
        cal_run <= go_write_set ? i_wdata[adcseq_pkg::CZ_CAL]
          : control_zero[adcseq_pkg::CZ_CAL];
      if (conv_end && cal_run)
        offset <= final_code;
    end
  end

  // Control registers; hardware go events win over software writes
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      control_zero <= adcseq_pkg::RESET_CONTROL;
      control_one <= adcseq_pkg::RESET_CONTROL;
      control_two <= adcseq_pkg::RESET_CONTROL;
      compare2_control <= adcseq_pkg::RESET_CONTROL;
    end else begin
      if (i_wr && i_addr == adcseq_pkg::ADDR_CONTROL_ZERO)
        control_zero <= i_wdata & adcseq_pkg::CZ_MASK;
      if (i_wr && i_addr == adcseq_pkg::ADDR_CONTROL_ONE)
        control_one <= i_wdata & adcseq_pkg::CO_MASK;
      if (i_wr && i_addr == adcseq_pkg::ADDR_CONTROL_TWO)
        control_two <= i_wdata & adcseq_pkg::CT_MASK;
      if (i_wr && i_addr == adcseq_pkg::ADDR_COMPARE2)
        compare2_control <= i_wdata & adcseq_pkg::CP_MASK;
      if (trigger_go && state == adcseq_pkg::ADCSEQ_IDLE)
        control_zero[adcseq_pkg::CZ_GO] <= 1'b1;
      if (conv_end)
        control_zero[adcseq_pkg::CZ_GO] <= 1'b0;
      if (!conv_on && !(i_wr && i_addr == adcseq_pkg::ADDR_CONTROL_ZERO))
        control_zero[adcseq_pkg::CZ_GO] <= 1'b0;
      if (i_wr && i_addr == adcseq_pkg::ADDR_CONTROL_ZERO && !conv_on)
        control_zero[adcseq_pkg::CZ_GO] <= 1'b0;
    end
  end

  // Result pair keeps its value through reset
  always_ff @(posedge i_clk) begin
    if (conv_end && !cal_run) begin
      if (control_two[adcseq_pkg::CT_JUSTIFY]) begin
        result_high <= {6'h00, corrected[9:8]};
        result_low <= corrected[7:0];
      end else begin
        result_high <= corrected[9:2];
        result_low <= {corrected[1:0], 6'h00};
      end
    end else begin
      if (i_wr && i_addr == adcseq_pkg::ADDR_RESULT_HIGH)
        result_high <= i_wdata;
      if (i_wr && i_addr == adcseq_pkg::ADDR_RESULT_LOW)
        result_low <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n)
      conversion_done_flag <= 1'b0;
    else if (conv_end)
      conversion_done_flag <= 1'b1;
    else if (i_wr && i_addr == adcseq_pkg::ADDR_STATUS && i_wdata[0])
      conversion_done_flag <= 1'b0;
  end

  // Read data one cycle after strobe
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !i_rd) begin
      o_rdata <= 8'h00;
    end else begin
      unique case (i_addr)
        adcseq_pkg::ADDR_RESULT_HIGH: o_rdata <= result_high;
        adcseq_pkg::ADDR_RESULT_LOW: o_rdata <= result_low;
        adcseq_pkg::ADDR_CONTROL_ZERO: o_rdata <= control_zero;
        adcseq_pkg::ADDR_CONTROL_ONE: o_rdata <= control_one;
        adcseq_pkg::ADDR_CONTROL_TWO: o_rdata <= control_two;
        adcseq_pkg::ADDR_STATUS: o_rdata <= {5'h00, busy, go_flag, conversion_done_flag};
        adcseq_pkg::ADDR_COMPARE2: o_rdata <= compare2_control;
        default: o_rdata <= 8'h00;
      endcase
    end
  end

  // Outputs to the analog array and neighbours
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_sample <= 1'b0;
      o_cal_mode <= 1'b0;
      o_channel <= 4'h0;
      o_timer_reset <= 1'b0;
      o_conversion_done_flag <= 1'b0;
      o_port_level <= 16'h0000;
    end else begin
      o_sample <= conv_on && (state == adcseq_pkg::ADCSEQ_IDLE
        || state == adcseq_pkg::ADCSEQ_ACQ);
      o_cal_mode <= cal_run && state == adcseq_pkg::ADCSEQ_CONV;
      o_channel <= control_zero[adcseq_pkg::CZ_CHS_LSB +: 4];
      // Timer reset regardless of converter state
      o_timer_reset <= i_special_event
        && compare2_control[3:0] == adcseq_pkg::COMPARE2_ADC_TRIGGER;
      o_conversion_done_flag <= conversion_done_flag;
      o_port_level <= i_pin_level & ~analog_mask(control_one[3:0]);
    end
  end

  // Channels at or below a threshold are analog; fifteen means none
  function automatic logic [15:0] analog_mask(input logic [3:0] cfg);
    logic [15:0] m;
    m = 16'h0000;
    for (int k = 0; k < 15; k++) begin
      if (4'(k) < 4'hF - cfg)
        m[k] = 1'b1;
    end
    return m;
  endfunction
endmodule

// ===== dv/adcseq_asserts.sv
// Port checker of the conversion sequencer
`timescale 1ns/1ps
module adcseq_asserts (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_special_event,
  input wire logic [15:0] i_pin_level,
  input wire logic [7:0] o_rdata,
  input wire logic o_sample,
  input wire logic o_cal_mode,
  input wire logic [3:0] o_channel,
  input wire logic o_timer_reset,
  input wire logic o_conversion_done_flag,
  input wire logic [15:0] o_port_level
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  logic [3:0] wr_ch;
  always_ff @(posedge i_clk) begin
    if (i_wr && i_addr == adcseq_pkg::ADDR_CONTROL_ZERO) begin
      wr_ch <= i_wdata[5:2];
    end
  end
  property p_rdata_idle;
    !$past(i_rd) |-> o_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its slot");
  property p_timer;
    o_timer_reset |-> $past(i_special_event);
  endproperty
  a_timer: assert property (p_timer) else $error("timer reset without trigger");
  property p_cal;
    o_cal_mode && $past(o_cal_mode) |-> !o_sample;
  endproperty
  a_cal: assert property (p_cal) else $error("input sampled in calibration");
  property p_wait;
    $rose(o_conversion_done_flag) |-> !o_sample [*2];
  endproperty
  a_wait: assert property (p_wait) else $error("sampling resumed too early");
  property p_port;
    (o_port_level & ~$past(i_pin_level)) == 16'h0000;
  endproperty
  a_port: assert property (p_port) else $error("port high on low pin");
  property p_channel;
    $past(i_wr && i_addr == adcseq_pkg::ADDR_CONTROL_ZERO) |-> ##[0:1] o_channel == wr_ch;
  endproperty
  a_channel: assert property (p_channel) else $error("channel not taken");
  property p_done_clear;
    $fell(o_conversion_done_flag) |->
      $past(i_wr && i_addr == adcseq_pkg::ADDR_STATUS && i_wdata[0], 2);
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done flag lost");
  property p_reset_off;
    $rose(i_rst_n) |-> !o_sample && !o_cal_mode && !o_conversion_done_flag && !o_timer_reset;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("outputs live after reset");
  c_cal: cover property (o_cal_mode);
  c_done: cover property ($rose(o_conversion_done_flag));
  c_timer: cover property (o_timer_reset);
endmodule
bind adcseq_top adcseq_asserts adcseq_asserts_inst (.*);

// ===== dv/adcseq_array_model.sv
// Sample-and-hold and comparator array model
`timescale 1ns/1ps
module adcseq_array_model #(
  parameter logic [9:0] OFFSET = 10'h003
) (
  input wire logic i_clk,
  input wire logic [9:0] i_dac_code,
  input wire logic i_sample,
  input wire logic i_cal_mode,
  input wire logic [9:0] i_level,
  output logic o_cmp_bit
);
  logic [9:0] held;
  // Holding capacitor freezes once sampling stops
  always @(posedge i_clk) begin
    if (i_sample) begin
      held <= i_level;
    end
  end
  assign o_cmp_bit = i_cal_mode ? (i_dac_code <= OFFSET) : (i_dac_code <= held + OFFSET);
endmodule

// ===== dv/test_adcseq_top.sv
// Self-checking bench of the conversion sequencer
`timescale 1ns/1ps
module test_adcseq_top;
  localparam logic [9:0] OFS = 10'h003;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, rc_tick = 0, sev = 0, cmp;
  logic [2:0] addr = 3'h0, rc_cnt = 3'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic [15:0] pins = 16'h0000, port;
  logic [9:0] level = 10'h2A5, dac;
  logic [3:0] chan;
  logic smp, cal, trst, done;
  int errors = 0, n_compared = 0, ba, bc, bw;
  adcseq_top adcseq_top_inst (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .i_rc_tick(rc_tick), .i_special_event(sev), .i_cmp_bit(cmp),
    .i_pin_level(pins), .o_rdata(rdata), .o_sample(smp), .o_cal_mode(cal), .o_dac_code(dac),
    .o_channel(chan), .o_timer_reset(trst), .o_conversion_done_flag(done), .o_port_level(port));
  adcseq_array_model #(.OFFSET(OFS)) adcseq_array_model_inst (.i_clk(clk), .i_dac_code(dac),
    .i_sample(smp), .i_cal_mode(cal), .i_level(level), .o_cmp_bit(cmp));
  initial forever #12.5 clk = ~clk;
  // Free-running RC source, one tick per five clocks
  always @(posedge clk) begin
    rc_cnt <= (rc_cnt == 3'h4) ? 3'h0 : rc_cnt + 3'h1;
    rc_tick <= (rc_cnt == 3'h4);
  end
  task automatic complete_run;
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input string w, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic check_rng(input string w, input int lo, input int hi, input int g);
    n_compared++;
    if (g < lo || g > hi) begin
      errors++;
      $display("ERROR %s expected %0d..%0d seen %0d", w, lo, hi, g);
    end
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input string w, input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
    check(w, {8'h00, e}, {8'h00, d});
  endtask
  task automatic wait_on(input int sel, input logic lvl, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 3000) begin
        errors++;
        $display("ERROR wait %0d expected %b seen timeout", sel, lvl);
        complete_run();
      end
    end while (((sel == 0) ? smp : done) !== lvl);
  endtask
  task automatic conv(input logic [7:0] ct, input logic [7:0] cz, output int a, c, w);
    wreg(adcseq_pkg::ADDR_STATUS, 8'h01);
    wreg(adcseq_pkg::ADDR_CONTROL_TWO, ct);
    wreg(adcseq_pkg::ADDR_CONTROL_ZERO, cz);
    wait_on(0, 1'b0, a);
    wait_on(1, 1'b1, c);
    wait_on(0, 1'b1, w);
  endtask
  task automatic fire(output logic t);
    sev <= 1'b1;
    @(posedge clk);
    sev <= 1'b0;
    #1 t = trst;
    @(posedge clk);
  endtask
  task automatic t_reset;
    rchk("control zero", adcseq_pkg::ADDR_CONTROL_ZERO, adcseq_pkg::RESET_CONTROL);
    rchk("control two", adcseq_pkg::ADDR_CONTROL_TWO, adcseq_pkg::RESET_CONTROL);
    rchk("unmapped", 3'h7, 8'h00);
    wreg(adcseq_pkg::ADDR_CONTROL_ONE, 8'hFF);
    rchk("control one", adcseq_pkg::ADDR_CONTROL_ONE, adcseq_pkg::CO_MASK);
  endtask
  task automatic t_go_off;
    wreg(adcseq_pkg::ADDR_CONTROL_ZERO, 8'h02);
    repeat (30) @(posedge clk);
    check("sample off", 16'h0000, {15'h0000, smp});
    rchk("status off", adcseq_pkg::ADDR_STATUS, 8'h00);
    wreg(adcseq_pkg::ADDR_CONTROL_ZERO, 8'h01);
    repeat (4) @(posedge clk);
  endtask
  task automatic t_periods;
    int f[8] = '{2, 4, 8, 16, 32, 64, 5, 5};
    logic [2:0] s[8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    int a, c, w, k, e;
    for (int i = 0; i < 8; i++) begin
      conv({5'h10, s[i]}, 8'h03, a, c, w);
      if (i == 0) begin
        ba = a;
        bc = c;
        bw = w;
      end
      // RC ticks run free, so allow one period of phase
      k = (i > 5) ? 5 : 0;
      e = bc + 11 * (f[i] - 2);
      check_rng("conversion", e - k, e + k, c);
      check_rng("wait", bw + 2 * (f[i] - 2) - k, bw + 2 * (f[i] - 2) + k, w);
    end
  endtask
  task automatic t_acq;
    int n[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    int a, c, w;
    for (int i = 1; i < 8; i++) begin
      conv({2'h2, i[2:0], 3'h0}, 8'h03, a, c, w);
      check_rng("acquisition", ba + 2 * n[i], ba + 2 * n[i] + 1, a);
      check_rng("start delay", bc - 6, bc - 4, c);
    end
  endtask
  task automatic t_result;
    logic [9:0] v;
    int a, c, w;
    v = level + OFS;
    conv(8'h80, 8'h3F, a, c, w);
    rchk("status done", adcseq_pkg::ADDR_STATUS, 8'h01);
    rchk("high right", adcseq_pkg::ADDR_RESULT_HIGH, {6'h00, v[9:8]});
    rchk("low right", adcseq_pkg::ADDR_RESULT_LOW, v[7:0]);
    conv(8'h00, 8'h3F, a, c, w);
    rchk("high left", adcseq_pkg::ADDR_RESULT_HIGH, v[9:2]);
    rchk("low left", adcseq_pkg::ADDR_RESULT_LOW, {v[1:0], 6'h00});
    wreg(adcseq_pkg::ADDR_CONTROL_ZERO, 8'h83);
    wait_on(0, 1'b0, a);
    wait_on(0, 1'b1, w);
    conv(8'h80, 8'h03, a, c, w);
    rchk("high cal", adcseq_pkg::ADDR_RESULT_HIGH, {6'h00, level[9:8]});
    rchk("low cal", adcseq_pkg::ADDR_RESULT_LOW, level[7:0]);
  endtask
  task automatic t_abort;
    int w;
    wreg(adcseq_pkg::ADDR_RESULT_HIGH, 8'h12);
    wreg(adcseq_pkg::ADDR_RESULT_LOW, 8'h34);
    wreg(adcseq_pkg::ADDR_STATUS, 8'h01);
    wreg(adcseq_pkg::ADDR_CONTROL_TWO, 8'h86);
    wreg(adcseq_pkg::ADDR_CONTROL_ZERO, 8'h03);
    repeat (200) @(posedge clk);
    wreg(adcseq_pkg::ADDR_CONTROL_ZERO, 8'h01);
    wait_on(0, 1'b1, w);
    check_rng("abort wait", 126, 200, w);
    check("done on abort", 16'h0000, {15'h0000, done});
    rchk("high kept", adcseq_pkg::ADDR_RESULT_HIGH, 8'h12);
    rchk("low kept", adcseq_pkg::ADDR_RESULT_LOW, 8'h34);
  endtask
  task automatic t_port;
    wreg(adcseq_pkg::ADDR_CONTROL_ONE, 8'h0B);
    pins <= 16'hA5A5;
    repeat (3) @(posedge clk);
    check("port level", 16'hA5A0, port);
    wreg(adcseq_pkg::ADDR_CONTROL_ZERO, 8'h25);
    // Channel output lands one edge after the register
    @(posedge clk);
    check("channel", 16'h0009, {12'h000, chan});
  endtask
  task automatic t_trigger;
    logic t;
    int c, w;
    wreg(adcseq_pkg::ADDR_CONTROL_TWO, 8'h80);
    wreg(adcseq_pkg::ADDR_COMPARE2, 8'h0B);
    wreg(adcseq_pkg::ADDR_STATUS, 8'h01);
    fire(t);
    check("timer reset", 16'h0001, {15'h0000, t});
    wait_on(1, 1'b1, c);
    wait_on(0, 1'b1, w);
    wreg(adcseq_pkg::ADDR_CONTROL_ZERO, 8'h00);
    wreg(adcseq_pkg::ADDR_STATUS, 8'h01);
    fire(t);
    check("timer reset off", 16'h0001, {15'h0000, t});
    repeat (40) @(posedge clk);
    check("trigger off", 16'h0000, {14'h0000, smp, done});
    wreg(adcseq_pkg::ADDR_COMPARE2, 8'h0A);
    fire(t);
    check("other mode", 16'h0000, {15'h0000, t});
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_go_off();
    t_periods();
    t_acq();
    t_result();
    t_abort();
    t_port();
    t_trigger();
    complete_run();
  end
endmodule
